// ### hdl/ots_pkg.sv
// Purpose: constants for the output terminal signal selector
// Assumes: setting codes held as 14-bit values (largest code 9999)
// Notes:   codes 0..99 positive logic, 100..199 negative logic, 9999 none
package ots_pkg;
	localparam int unsigned CODE_W        = 14;
	localparam int unsigned NUM_TERM      = 3;
	localparam int unsigned TERM_OC_A     = 0;
	localparam int unsigned TERM_OC_B     = 1;
	localparam int unsigned TERM_RELAY    = 2;
	localparam logic [13:0] RST_OC_A      = 14'h0000;
	localparam logic [13:0] RST_OC_B      = 14'h0004;
	localparam logic [13:0] RST_RELAY     = 14'h0063;
	localparam logic [13:0] NEG_OFFSET    = 14'h0064;
	localparam logic [13:0] NEG_LAST      = 14'h00c7;
	localparam logic [13:0] CODE_NONE     = 14'h270f;
	// positive-logic function codes
	localparam logic [6:0]  F_RUN         = 7'h00;
	localparam logic [6:0]  F_SU          = 7'h01;
	localparam logic [6:0]  F_OL          = 7'h03;
	localparam logic [6:0]  F_FU          = 7'h04;
	localparam logic [6:0]  F_RBP         = 7'h07;
	localparam logic [6:0]  F_THP         = 7'h08;
	localparam logic [6:0]  F_RY          = 7'h0b;
	localparam logic [6:0]  F_Y12         = 7'h0c;
	localparam logic [6:0]  F_Y13         = 7'h0d;
	localparam logic [6:0]  F_FDN         = 7'h0e;
	localparam logic [6:0]  F_FUP         = 7'h0f;
	localparam logic [6:0]  F_RL          = 7'h10;
	localparam logic [6:0]  F_BOF         = 7'h14;
	localparam logic [6:0]  F_FAN         = 7'h19;
	localparam logic [6:0]  F_FIN         = 7'h1a;
	localparam logic [6:0]  F_Y46         = 7'h2e;
	localparam logic [6:0]  F_PID         = 7'h2f;
	localparam logic [6:0]  F_Y64         = 7'h40;
	localparam logic [6:0]  F_Y90         = 7'h5a;
	localparam logic [6:0]  F_Y91         = 7'h5b;
	localparam logic [6:0]  F_Y93         = 7'h5d;
	localparam logic [6:0]  F_Y95         = 7'h5f;
	localparam logic [6:0]  F_REM         = 7'h60;
	localparam logic [6:0]  F_LF          = 7'h62;
	localparam logic [6:0]  F_ALM         = 7'h63;
	// prealarm ratio, percent of full scale
	localparam int unsigned PREALARM_PCT  = 85;
	localparam int unsigned FULL_PCT      = 100;
	localparam int unsigned LVL_W         = 16;
	localparam int unsigned TIME_W        = 16;
	localparam int unsigned FREQ_W        = 16;
endpackage

// ### hdl/ots_timed_detect.sv
// Purpose: flags a condition held continuously longer than a cycle count
// Assumes: cond comes from logic on sys_clk
// Notes:   any gap in cond restarts the count
`timescale 1ns/1ps
module ots_timed_detect
	import ots_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	// condition and hold time
	input  wire logic              cond,
	input  wire logic [TIME_W-1:0] hold_cycles,
	// result
	output logic                   detect
);
	logic [TIME_W-1:0] cnt_reg;
	logic [TIME_W-1:0] cnt_next;
	logic              det_reg;
	logic              det_next;

	// count while held; saturate once detect is up
	always_comb begin
		cnt_next = cnt_reg;
		det_next = det_reg;
		if (!cond) begin
			cnt_next = '0;
			det_next = 1'b0;
		end else if (cnt_reg >= hold_cycles) begin
			det_next = 1'b1; // strictly longer than the hold time
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
			det_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			det_reg <= det_next;
		end
	end

	assign detect = det_reg;
endmodule

// ### hdl/ots_selector.sv
// Purpose: builds drive status conditions and routes them to three output terminals
// Assumes: all status inputs come from logic on sys_clk
// Notes:   terminal outputs are conduct levels, registered
`timescale 1ns/1ps
module ots_selector
	import ots_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	// setting writes, one strobe per terminal
	input  wire logic [2:0]        set_wr,
	input  wire logic [CODE_W-1:0] set_code,
	output logic                   set_refused,
	output logic [CODE_W-1:0]      oc_terminal_a_select,
	output logic [CODE_W-1:0]      oc_terminal_b_select,
	output logic [CODE_W-1:0]      relay_terminal_select,
	// drive state
	input  wire logic              drive_running,
	input  wire logic              drive_reverse,
	input  wire logic              init_done,
	input  wire logic              output_shutoff,
	input  wire logic [FREQ_W-1:0] out_freq,
	input  wire logic [FREQ_W-1:0] set_freq,
	input  wire logic [FREQ_W-1:0] start_freq,
	input  wire logic [FREQ_W-1:0] fwd_detect_freq,
	input  wire logic [FREQ_W-1:0] rev_detect_freq,
	input  wire logic              stall_active,
	// levels against limits
	input  wire logic [LVL_W-1:0]  regen_duty,
	input  wire logic [LVL_W-1:0]  regen_duty_limit,
	input  wire logic [LVL_W-1:0]  thermal_level,
	input  wire logic [LVL_W-1:0]  thermal_trip,
	input  wire logic [LVL_W-1:0]  heatsink_temp,
	input  wire logic [LVL_W-1:0]  heatsink_trip,
	input  wire logic [LVL_W-1:0]  out_current,
	input  wire logic [LVL_W-1:0]  current_thresh,
	input  wire logic [TIME_W-1:0] current_hold,
	input  wire logic [LVL_W-1:0]  out_power,
	input  wire logic [LVL_W-1:0]  zero_thresh,
	input  wire logic [TIME_W-1:0] zero_hold,
	// PID, brake and misc conditions
	input  wire logic              pid_active,
	input  wire logic              pid_feedback_low,
	input  wire logic              pid_feedback_high,
	input  wire logic              pid_forward,
	input  wire logic              brake_seq_enable,
	input  wire logic              brake_open_cmd,
	input  wire logic              fan_fault,
	input  wire logic              outage_decel_start,
	input  wire logic              outage_release,
	input  wire logic              retry_busy,
	input  wire logic              wearout_any,
	input  wire logic              fault_internal,
	input  wire logic              current_avg_pulse,
	input  wire logic              maint_timer_due,
	input  wire logic              remote_bit,
	input  wire logic              minor_alarm,
	input  wire logic              fault_active,
	// conduct level per terminal
	output logic                   oc_terminal_a_on,
	output logic                   oc_terminal_b_on,
	output logic                   relay_terminal_on
);
	// stored settings, refusal pulse, outage latch and terminal levels
	logic [CODE_W-1:0] sel_reg  [NUM_TERM];
	logic [CODE_W-1:0] sel_next [NUM_TERM];
	logic              refused_reg;
	logic              refused_next;
	logic              outage_reg;
	logic              outage_next;
	logic [NUM_TERM-1:0] on_reg;
	logic [NUM_TERM-1:0] on_next;

	// one slot per positive-logic code; unused slots stay low
	logic [127:0]      func_vec;
	// named status conditions
	logic              frequency_reached_flag;
	logic              stall_active_flag;
	logic              frequency_detect_flag;
	logic              regen_duty_prealarm;
	logic              thermal_prealarm;
	logic              drive_operable_flag;
	logic              overcurrent_detect_flag;
	logic              low_current_detect_flag;
	logic              feedback_low_limit_flag;
	logic              feedback_high_limit_flag;
	logic              loop_forward_flag;
	logic              brake_release_request;
	logic              heatsink_prealarm;
	logic              outage_decel_flag;
	logic              retry_active_flag;
	logic              wearout_alarm_flag;
	logic              fault_output_flag;

	// running level and raw comparisons for the timed detectors
	logic              run_flag;
	logic              cur_over;
	logic              pow_under;

	// code 0..99 with a defined function
	function automatic logic func_listed(input logic [6:0] f);
		case (f)
			F_RUN, F_SU, F_OL, F_FU, F_RBP, F_THP, F_RY, F_Y12, F_Y13,
			F_FDN, F_FUP, F_RL, F_BOF, F_FAN, F_FIN, F_Y46, F_PID, F_Y64,
			F_Y90, F_Y91, F_Y93, F_Y95, F_REM, F_LF, F_ALM: func_listed = 1'b1;
			default: func_listed = 1'b0;
		endcase
	endfunction

	// legal setting for a terminal; relay may not carry the pulse monitor
	function automatic logic code_ok(input logic [CODE_W-1:0] c, input logic relay);
		logic [CODE_W-1:0] base;
		// strip the negative-logic offset before the lookup
		base = (c >= NEG_OFFSET) ? c - NEG_OFFSET : c;
		if (c == CODE_NONE)
			code_ok = 1'b1;
		else if (c > NEG_LAST)
			code_ok = 1'b0;
		else if (relay && base[6:0] == F_Y93)
			code_ok = 1'b0;
		else
			code_ok = func_listed(base[6:0]);
	endfunction

	// level at or above 85 percent of a limit, widened to avoid overflow
	function automatic logic prealarm(input logic [LVL_W-1:0] v, input logic [LVL_W-1:0] lim);
		logic [LVL_W+7:0] lhs;
		logic [LVL_W+7:0] rhs;
		// compare v*100 against lim*85 so no division is needed
		lhs = {8'h00, v} * (LVL_W+8)'(FULL_PCT);
		rhs = {8'h00, lim} * (LVL_W+8)'(PREALARM_PCT);
		prealarm = (lim != '0) && (lhs >= rhs);
	endfunction

	// conduct level from a setting and the function vector
	function automatic logic term_level(input logic [CODE_W-1:0] c, input logic [127:0] fv);
		logic [CODE_W-1:0] base;
		logic              neg;
		base = (c >= NEG_OFFSET) ? c - NEG_OFFSET : c;
		neg  = (c >= NEG_OFFSET);
		// out-of-range and unlisted codes never conduct
		if (c > NEG_LAST)
			term_level = 1'b0;
		else if (!func_listed(base[6:0]))
			term_level = 1'b0;
		else
			term_level = fv[base[6:0]] ^ neg;
	endfunction

	// timed current detectors
	// a hold of zero still needs one cycle of condition first
	assign cur_over  = out_current > current_thresh;
	assign pow_under = out_power < zero_thresh;

	ots_timed_detect u_over_det (
		.sys_clk     (sys_clk),
		.arst_n      (arst_n),
		.cond        (cur_over),
		.hold_cycles (current_hold),
		.detect      (overcurrent_detect_flag)
	);

	ots_timed_detect u_zero_det (
		.sys_clk     (sys_clk),
		.arst_n      (arst_n),
		.cond        (pow_under),
		.hold_cycles (zero_hold),
		.detect      (low_current_detect_flag)
	);

	// status conditions
	assign run_flag = drive_running && (out_freq >= start_freq);
	assign frequency_reached_flag = drive_running && (out_freq == set_freq);
	assign stall_active_flag = stall_active;
	// reverse rotation switches to its own threshold
	assign frequency_detect_flag =
		out_freq >= (drive_reverse ? rev_detect_freq : fwd_detect_freq);
	assign regen_duty_prealarm = prealarm(regen_duty, regen_duty_limit);
	assign thermal_prealarm = prealarm(thermal_level, thermal_trip);
	// ready also stays on while running, off at output shutoff
	assign drive_operable_flag = init_done && !output_shutoff;
	assign feedback_low_limit_flag  = pid_active && pid_feedback_low;
	assign feedback_high_limit_flag = pid_active && pid_feedback_high;
	assign loop_forward_flag        = pid_active && pid_forward;
	assign brake_release_request = brake_seq_enable && brake_open_cmd;
	assign heatsink_prealarm = prealarm(heatsink_temp, heatsink_trip);
	assign outage_decel_flag = outage_reg;
	assign retry_active_flag = retry_busy;
	assign wearout_alarm_flag = wearout_any;
	assign fault_output_flag = fault_active;

	// function vector indexed by positive-logic code
	always_comb begin
		func_vec = '0;
		func_vec[F_RUN] = run_flag;
		func_vec[F_SU]  = frequency_reached_flag;
		func_vec[F_OL]  = stall_active_flag;
		func_vec[F_FU]  = frequency_detect_flag;
		func_vec[F_RBP] = regen_duty_prealarm;
		func_vec[F_THP] = thermal_prealarm;
		func_vec[F_RY]  = drive_operable_flag;
		func_vec[F_Y12] = overcurrent_detect_flag;
		func_vec[F_Y13] = low_current_detect_flag;
		func_vec[F_FDN] = feedback_low_limit_flag;
		func_vec[F_FUP] = feedback_high_limit_flag;
		func_vec[F_RL]  = loop_forward_flag;
		func_vec[F_BOF] = brake_release_request;
		func_vec[F_FAN] = fan_fault;
		func_vec[F_FIN] = heatsink_prealarm;
		func_vec[F_Y46] = outage_decel_flag;
		func_vec[F_PID] = pid_active;
		func_vec[F_Y64] = retry_active_flag;
		func_vec[F_Y90] = wearout_alarm_flag;
		// remaining codes map straight to their inputs
		func_vec[F_Y91] = fault_internal;
		func_vec[F_Y93] = current_avg_pulse;
		func_vec[F_Y95] = maint_timer_due;
		func_vec[F_REM] = remote_bit;
		func_vec[F_LF]  = minor_alarm;
		func_vec[F_ALM] = fault_output_flag;
	end

	// settings, outage latch and terminal levels
	always_comb begin
		for (int i = 0; i < NUM_TERM; i++) begin
			sel_next[i] = sel_reg[i];
		end
		refused_next = 1'b0;
		// an illegal code keeps the old setting and only pulses the refusal
		// several strobes at once write the same code to each strobed terminal, except the pulse monitor on the relay
		for (int i = 0; i < NUM_TERM; i++) begin
			if (set_wr[i]) begin
				if (code_ok(set_code, i == TERM_RELAY))
					sel_next[i] = set_code;
				else
					refused_next = 1'b1;
			end
		end
		// start wins over release so a new outage is never lost
		outage_next = outage_reg;
		if (outage_release)
			outage_next = 1'b0;
		if (outage_decel_start)
			outage_next = 1'b1;
		// levels use the stored settings, so a new code shows one cycle later
		for (int i = 0; i < NUM_TERM; i++) begin
			on_next[i] = term_level(sel_reg[i], func_vec);
		end
	end

	// register stage; settings restart at defaults
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_reg[TERM_OC_A]  <= RST_OC_A;
			sel_reg[TERM_OC_B]  <= RST_OC_B;
			sel_reg[TERM_RELAY] <= RST_RELAY;
			refused_reg         <= 1'b0;
			outage_reg          <= 1'b0;
			on_reg              <= '0;
		end else begin
			for (int i = 0; i < NUM_TERM; i++) begin
				sel_reg[i] <= sel_next[i];
			end
			refused_reg <= refused_next;
			outage_reg  <= outage_next;
			on_reg      <= on_next;
		end
	end

	// every output straight from a flop, no logic behind it
	assign oc_terminal_a_select  = sel_reg[TERM_OC_A];
	assign oc_terminal_b_select  = sel_reg[TERM_OC_B];
	assign relay_terminal_select = sel_reg[TERM_RELAY];
	assign set_refused           = refused_reg;
	assign oc_terminal_a_on      = on_reg[TERM_OC_A];
	assign oc_terminal_b_on      = on_reg[TERM_OC_B];
	assign relay_terminal_on     = on_reg[TERM_RELAY];
endmodule

// ### verif/ots_selector_chk.sv
// Purpose: port-level checks for the output terminal selector
// Assumes: bound to ots_selector, single sys_clk domain
// Notes:   timed detector latency is left to the bench, it is loose by design
`timescale 1ns/1ps
module ots_selector_chk
	import ots_pkg::*;
(
	// clock and reset
	input wire logic              sys_clk,
	input wire logic              arst_n,
	// setting path
	input wire logic [2:0]        set_wr,
	input wire logic [CODE_W-1:0] set_code,
	input wire logic              set_refused,
	input wire logic [CODE_W-1:0] oc_terminal_a_select,
	input wire logic [CODE_W-1:0] oc_terminal_b_select,
	input wire logic [CODE_W-1:0] relay_terminal_select,
	// conditions and terminals
	input wire logic              drive_running,
	input wire logic              brake_seq_enable,
	input wire logic              fan_fault,
	input wire logic              oc_terminal_a_on,
	input wire logic              oc_terminal_b_on,
	input wire logic              relay_terminal_on
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// settings and refusals
	property p_rst; $rose(arst_n) |-> oc_terminal_a_select == RST_OC_A &&
		oc_terminal_b_select == RST_OC_B && relay_terminal_select == RST_RELAY; endproperty
	a_rst: assert property (p_rst) else $error("select reset value wrong");
	property p_wr_a; set_wr == 3'h1 && set_code == 14'h0001 |=>
		oc_terminal_a_select == 14'h0001; endproperty
	a_wr_a: assert property (p_wr_a) else $error("terminal a write lost");
	property p_relay_ref; set_wr == 3'h4 && set_code == 14'h005d |=> set_refused &&
		$stable(relay_terminal_select); endproperty
	a_relay_ref: assert property (p_relay_ref) else $error("relay took pulse monitor code");
	property p_bad; set_wr != 3'h0 && set_code == 14'h0002 |=> set_refused; endproperty
	a_bad: assert property (p_bad) else $error("unlisted code not refused");
	property p_quiet; set_wr == 3'h0 |=> !set_refused; endproperty
	a_quiet: assert property (p_quiet) else $error("refusal without a write");
	// terminal levels, one cycle behind their cause
	property p_fan; oc_terminal_a_select == 14'h0019 && fan_fault |=> oc_terminal_a_on; endproperty
	a_fan: assert property (p_fan) else $error("fan fault not shown");
	property p_neg; oc_terminal_b_select == 14'h007d && fan_fault |=> !oc_terminal_b_on; endproperty
	a_neg: assert property (p_neg) else $error("negative code conducts");
	property p_same; oc_terminal_a_select == oc_terminal_b_select |=>
		oc_terminal_a_on == oc_terminal_b_on; endproperty
	a_same: assert property (p_same) else $error("shared selection differs");
	property p_none; relay_terminal_select == CODE_NONE |=> !relay_terminal_on; endproperty
	a_none: assert property (p_none) else $error("no-function relay conducts");
	property p_brake; oc_terminal_a_select == 14'h0014 && !brake_seq_enable |=> !oc_terminal_a_on;
		endproperty
	a_brake: assert property (p_brake) else $error("brake request outside sequence");
	property p_run; oc_terminal_b_select == 14'h0000 && !drive_running |=> !oc_terminal_b_on;
		endproperty
	a_run: assert property (p_run) else $error("running shown while stopped");
	// main scenarios reached
	c_ref: cover property (set_refused);
	c_both: cover property (oc_terminal_a_on && relay_terminal_on);
	c_rise: cover property ($rose(oc_terminal_b_on));
endmodule

bind ots_selector ots_selector_chk u_ots_selector_chk (.sys_clk, .arst_n, .set_wr, .set_code,
	.set_refused, .oc_terminal_a_select, .oc_terminal_b_select, .relay_terminal_select,
	.drive_running, .brake_seq_enable, .fan_fault, .oc_terminal_a_on, .oc_terminal_b_on,
	.relay_terminal_on);

// ### verif/ots_load_model.sv
// Purpose: load side that senses the three output terminals
// Assumes: open-collector lines pulled up at the load
// Notes:   a conducting transistor pulls its line low, relay reads closed
`timescale 1ns/1ps
module ots_load_model (
	// terminal drive
	input  wire logic oc_a_on,
	input  wire logic oc_b_on,
	input  wire logic relay_on,
	// sensed levels
	output logic      oc_a_line,
	output logic      oc_b_line,
	output logic      relay_closed
);
	// pull-up wins whenever the transistor is off
	assign oc_a_line    = !oc_a_on;
	assign oc_b_line    = !oc_b_on;
	assign relay_closed = relay_on;
endmodule

// ### verif/ots_selector_bench.sv
// Purpose: self-checking bench for the output terminal selector
// Assumes: inputs change by non-blocking assignment on the rising edge
// Notes:   codes 12 and 13 stay out of the random phase, timed once each at the end
`timescale 1ns/1ps
module ots_selector_bench;
	import ots_pkg::*;
	// design signals
	logic              sys_clk, arst_n, set_refused, oc_a_line, oc_b_line, relay_closed;
	logic [2:0]        set_wr;
	logic [CODE_W-1:0] set_code, oc_terminal_a_select, oc_terminal_b_select, relay_terminal_select;
	logic              oc_terminal_a_on, oc_terminal_b_on, relay_terminal_on;
	logic              drive_running, drive_reverse, init_done, output_shutoff, stall_active;
	logic              pid_active, pid_feedback_low, pid_feedback_high, pid_forward;
	logic              brake_seq_enable, brake_open_cmd, fan_fault, outage_decel_start;
	logic              outage_release, retry_busy, wearout_any, fault_internal;
	logic              current_avg_pulse, maint_timer_due, remote_bit, minor_alarm, fault_active;
	logic [LVL_W-1:0]  out_freq, set_freq, start_freq, fwd_detect_freq, rev_detect_freq;
	logic [LVL_W-1:0]  regen_duty, regen_duty_limit, thermal_level, thermal_trip;
	logic [LVL_W-1:0]  heatsink_temp, heatsink_trip, out_current, current_thresh;
	logic [LVL_W-1:0]  current_hold, out_power, zero_thresh, zero_hold;
	// model state
	int                error_cnt, comparisons, seed, n, pk;
	int                msel[3];
	logic [2:0]        exp_on, skip;
	logic              exp_ref, rnd_on, mout;
	int                pool[27] = '{0, 1, 2, 3, 4, 7, 8, 11, 14, 15, 16, 20, 25, 26, 46, 47, 64,
		90, 91, 93, 95, 96, 98, 99, 9999, 5, 16383};
	logic [2:0]        wpick[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};

	ots_selector u_ots_selector (.*);
	ots_load_model u_ots_load_model (.oc_a_on(oc_terminal_a_on), .oc_b_on(oc_terminal_b_on),
		.relay_on(relay_terminal_on), .oc_a_line(oc_a_line), .oc_b_line(oc_b_line),
		.relay_closed(relay_closed));

	always #2 sys_clk = !sys_clk;

	// listed codes only; the relay refuses the pulse monitor
	function automatic bit legal(int c, int t);
		if (c == 9999) return 1;
		if (c > 199 || (t == 2 && c % 100 == 93)) return 0;
		return (c % 100) inside {0, 1, 3, 4, 7, 8, [11:16], 20, 25, 26, 46, 47, 64, 90, 91, 93,
			95, 96, 98, 99};
	endfunction
	// prealarm at 85 percent of a non-zero limit
	function automatic bit pre(int v, int l);
		return l != 0 && v * 100 >= l * 85;
	endfunction
	// selected condition before polarity
	function automatic bit sig(int b);
		case (b)
			0: return drive_running && out_freq >= start_freq;
			1: return drive_running && out_freq == set_freq;
			3: return stall_active;
			4: return out_freq >= (drive_reverse ? rev_detect_freq : fwd_detect_freq);
			7: return pre(regen_duty, regen_duty_limit);
			8: return pre(thermal_level, thermal_trip);
			11: return init_done && !output_shutoff;
			14: return pid_active && pid_feedback_low;
			15: return pid_active && pid_feedback_high;
			16: return pid_active && pid_forward;
			20: return brake_seq_enable && brake_open_cmd;
			25: return fan_fault;
			26: return pre(heatsink_temp, heatsink_trip);
			46: return mout;
			47: return pid_active;
			64: return retry_busy;
			90: return wearout_any;
			91: return fault_internal;
			93: return current_avg_pulse;
			95: return maint_timer_due;
			96: return remote_bit;
			98: return minor_alarm;
			99: return fault_active;
			default: return 0;
		endcase
	endfunction

	task automatic check(logic [15:0] seen, logic [15:0] want);
		comparisons++;
		if (seen !== want) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic final_report;
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// fresh drive conditions; masks keep equal frequencies and short holds likely
	task automatic rnd_cond;
		{drive_running, drive_reverse, init_done, output_shutoff, stall_active, pid_active,
			pid_feedback_low, pid_feedback_high, pid_forward, brake_seq_enable, brake_open_cmd,
			fan_fault, outage_decel_start, outage_release, retry_busy, wearout_any, fault_internal,
			current_avg_pulse, maint_timer_due, remote_bit, minor_alarm, fault_active}
			<= 22'($random(seed));
		{out_freq, set_freq, start_freq, fwd_detect_freq, rev_detect_freq}
			<= 80'({$random(seed), $random(seed), $random(seed)}) & {5{16'h0003}};
		{regen_duty, regen_duty_limit, thermal_level, thermal_trip, heatsink_temp, heatsink_trip}
			<= {$random(seed), $random(seed), $random(seed)};
		{out_current, current_thresh, out_power, zero_thresh} <= {$random(seed), $random(seed)};
		{current_hold, zero_hold} <= $random(seed) & 32'h00070007;
	endtask

	// hold a timed condition, then time the terminal's rise; cur picks terminal a
	task automatic timed(logic [2:0] w, logic [13:0] c, bit cur);
		set_wr <= w;
		set_code <= c;
		@(posedge sys_clk);
		set_wr <= 3'h0;
		repeat (8) @(posedge sys_clk);
		check(cur ? oc_terminal_a_on : oc_terminal_b_on, 0);
		if (cur) out_current <= 16'h0014;
		else out_power <= 16'h0000;
		n = 0;
		while ((cur ? oc_terminal_a_on : oc_terminal_b_on) !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		// hold 3: three cycles of condition, flag flop, terminal flop, then seen
		check(n, 6);
		if (n >= 20) final_report();
	endtask

	// random writes and conditions
	always @(posedge sys_clk) begin
		if (rnd_on) begin
			rnd_cond();
			pk = pool[$unsigned($random(seed)) % 27];
			set_wr <= wpick[$unsigned($random(seed)) % 5];
			set_code <= 14'(pk + ((pk < 100 && $random(seed) % 2 != 0) ? 100 : 0));
		end
	end

	// model one registered stage behind the inputs, compared at every edge
	always @(posedge sys_clk) begin
		if (!arst_n) begin
			msel = '{0, 4, 99};
			exp_on = 3'h0;
			skip = 3'h0;
			exp_ref = 0;
			mout = 0;
		end else begin
			check(set_refused, exp_ref);
			check(oc_terminal_a_select, msel[0]);
			check(oc_terminal_b_select, msel[1]);
			check(relay_terminal_select, msel[2]);
			if (!skip[0]) check(oc_a_line, !exp_on[0]);
			if (!skip[1]) check(oc_b_line, !exp_on[1]);
			if (!skip[2]) check(relay_closed, exp_on[2]);
			exp_ref = 0;
			for (int i = 0; i < 3; i++) begin
				exp_on[i] = msel[i] > 199 ? 0 : msel[i] < 100 ? sig(msel[i]) : !sig(msel[i] - 100);
				skip[i] = msel[i] < 200 && (msel[i] % 100) inside {12, 13};
				if (set_wr[i] && legal(int'(set_code), i)) msel[i] = set_code;
				else if (set_wr[i]) exp_ref = 1;
			end
			// outage latch: a start in the same cycle as a release wins
			if (outage_decel_start) mout = 1;
			else if (outage_release) mout = 0;
		end
	end

	initial begin
		sys_clk = 0;
		arst_n = 0;
		rnd_on = 0;
		seed = 32'h5953c858;
		set_wr = 3'h0;
		set_code = 14'h0000;
		rnd_cond();
		repeat (10) @(posedge sys_clk);
		arst_n <= 1;
		rnd_on <= 1;
		repeat (3000) @(posedge sys_clk);
		rnd_on <= 0;
		@(posedge sys_clk);
		{current_thresh, current_hold, zero_thresh, zero_hold} <= 64'h000a_0003_000a_0003;
		{out_current, out_power} <= 32'h0000_0100;
		timed(3'h1, 14'h000c, 1);
		timed(3'h2, 14'h000d, 0);
		arst_n <= 0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1;
		repeat (4) @(posedge sys_clk);
		final_report();
	end
endmodule
